// ===== dcc_top.sv
// Four-channel DMA controller: host register port and transfer engine
//
// Function
// - Reset and master clear zero the command register.
// - Command bit 7 sets grant polarity, bit 6 inverts request lines.
// - Timing bit picks normal or 2-cycle compressed; write bit extends writes.
// - Fixed priority favours line 0; rotating puts last served lowest.
// - Disable bit keeps the engine idle until written back to zero.
// - Command bit 1 holds channel 0 address constant.
// - Memory copy reads channel 0 into temp, writes to channel 1.
// - Mode write applies to the channel named in its two select bits.
// - Mode field: demand 0, single 1, block 2, cascade 3.
// - Single mode does one transfer then releases the bus.
// - Terminal count when current count steps from 0 to FFFF.
// - Block mode runs until terminal count or external end.
// - Demand mode pauses when request drops and resumes when it returns.
// - Mode bit 5 picks address increment (0) or decrement (1).
// - Auto-initialize reloads current from base; transfers leave base alone.
// - Direction: verify 0, to memory 1, from memory 2; verify writes nothing.
// - Request write sets or clears a software request; mask ignored.
// - Single mask, all mask and clear mask writes update channel masks.
// - End without auto-initialize masks the channel; reset masks all.
// - Status low bits flag ends, clear on read; high bits show requests.
// - Temp holds last copied byte, readable, cleared at reset.
// - Writing current registers also loads base; base unreadable.
// - Byte pointer selects low then high byte, toggles, software clearable.
// - A valid request raises hold request; transfers wait for hold grant.
`timescale 1ns/1ps
`default_nettype none

module dcc_top (
    // Clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst_b,
    // Host register port
    input  wire dcc_pkg::dcc_host_in_t  host_i,
    output var  dcc_pkg::dcc_host_out_t host_o,
    // Peripheral and bus handshake
    input  wire logic [3:0]             service_request_line,
    input  wire logic                   bus_hold_grant,
    input  wire logic                   ready,
    input  wire logic                   end_of_process_in_n,
    output var  dcc_pkg::dcc_xfer_out_t xfer_o
);
    dcc_pkg::dcc_regs_t r;
    dcc_pkg::dcc_regs_t next_r;

    logic [3:0]  req_act;
    logic [3:0]  pend;
    logic [1:0]  sel;
    logic [1:0]  idx;
    logic        found;
    logic        idle;
    logic        wr_go;
    logic        rd_go;
    logic [1:0]  pch;
    logic [1:0]  xm;
    logic [1:0]  dir;
    logic        copy;
    logic        compressed;
    logic        ending;
    logic [1:0]  ech;
    logic [15:0] step;
    logic        rd_act;
    logic        wr_act;
    logic        xfer_on;
    logic [3:0]  grant;

    assign host_o = r.ho;
    assign xfer_o = r.xo;

    always_comb begin
        next_r = r;
        idle   = (r.st == dcc_pkg::DCC_IDLE);
        // Requests arrive in the polarity the command byte selects
        req_act = r.cmd[dcc_pkg::C_REQ_LOW] ? ~service_request_line
                                            : service_request_line;
        pend = (req_act & ~r.mask) | r.sw_req;
        found = 1'b0;
        sel   = 2'h0;
        idx   = 2'h0;
        for (int i = 0; i < dcc_pkg::NCH; i++) begin
            idx = r.cmd[dcc_pkg::C_PRIORITY_SCHEME_SELECT] ? r.last + 2'(i + 1) : 2'(i);
            if (!found && pend[idx]) begin
                found = 1'b1;
                sel   = idx;
            end
        end

        // Host port: registers are reachable only while idle
        next_r.wr_seen = ~host_i.cs_n & ~host_i.wr_n;
        next_r.rd_seen = ~host_i.cs_n & ~host_i.rd_n;
        wr_go = next_r.wr_seen & ~r.wr_seen & idle;
        rd_go = next_r.rd_seen & ~r.rd_seen & idle;
        pch   = host_i.a[dcc_pkg::A_CH_LO +: 2];
        if (wr_go) begin
            if (!host_i.a[dcc_pkg::A_WIDE]) begin
                if (host_i.a[dcc_pkg::A_COUNT]) begin
                    next_r.cur_cnt[pch][r.ptr*8 +: 8]  = host_i.d;
                    next_r.base_cnt[pch][r.ptr*8 +: 8] = host_i.d;
                end else begin
                    next_r.cur_addr[pch][r.ptr*8 +: 8]  = host_i.d;
                    next_r.base_addr[pch][r.ptr*8 +: 8] = host_i.d;
                end
                next_r.ptr = ~r.ptr;
            end else begin
                unique case (host_i.a)
                    dcc_pkg::P_STAT_CMD: next_r.cmd = host_i.d;
                    dcc_pkg::P_REQ:
                        next_r.sw_req[host_i.d[dcc_pkg::SEL_LO +: 2]] =
                            host_i.d[dcc_pkg::SET_BIT];
                    dcc_pkg::P_SMASK:
                        next_r.mask[host_i.d[dcc_pkg::SEL_LO +: 2]] =
                            host_i.d[dcc_pkg::SET_BIT];
                    dcc_pkg::P_MODE:
                        next_r.mode[host_i.d[dcc_pkg::SEL_LO +: 2]] =
                            host_i.d;
                    dcc_pkg::P_CLR_PTR: next_r.ptr = 1'b0;
                    dcc_pkg::P_TEMP_MCLR: begin
                        next_r.cmd     = dcc_pkg::CMD_RST;
                        next_r.mask    = dcc_pkg::MASK_RST;
                        next_r.sw_req  = '0;
                        next_r.tc_flag = '0;
                        next_r.temp    = '0;
                        next_r.ptr     = 1'b0;
                    end
                    dcc_pkg::P_CLR_MASK: next_r.mask = '0;
                    dcc_pkg::P_AMASK: next_r.mask = host_i.d[3:0];
                    default: next_r.cmd = r.cmd;
                endcase
            end
        end
        if (rd_go) begin
            next_r.ho.d = dcc_pkg::READ_NONE;
            if (!host_i.a[dcc_pkg::A_WIDE]) begin
                // Base registers have no read path
                next_r.ho.d = host_i.a[dcc_pkg::A_COUNT]
                    ? r.cur_cnt[pch][r.ptr*8 +: 8]
                    : r.cur_addr[pch][r.ptr*8 +: 8];
                next_r.ptr = ~r.ptr;
            end else if (host_i.a == dcc_pkg::P_STAT_CMD) begin
                next_r.ho.d    = {req_act, r.tc_flag};
                next_r.tc_flag = '0;
            end else if (host_i.a == dcc_pkg::P_TEMP_MCLR) begin
                next_r.ho.d = r.temp;
            end
        end

        // Transfer engine
        xm   = r.mode[r.ch][dcc_pkg::MB_XM +: 2];
        dir  = r.mode[r.ch][dcc_pkg::MB_DIR +: 2];
        copy = r.cmd[dcc_pkg::C_MEMCPY] && (r.ch == 2'h0);
        compressed = r.cmd[dcc_pkg::C_TIMING];
        ech    = copy ? 2'h1 : r.ch;
        ending = 1'b0;
        step   = r.mode[ech][dcc_pkg::MB_DEC] ? ~dcc_pkg::CNT_ZERO
                                                 : dcc_pkg::STEP_ONE;
        // Temp follows the data bus while the copy read strobe is out
        if (!r.xo.memr_n && copy && !r.phase) begin
            next_r.temp = host_i.d;
        end
        unique case (r.st)
            dcc_pkg::DCC_IDLE: begin
                if (!r.cmd[dcc_pkg::C_DISABLE] && found) begin
                    next_r.ch    = sel;
                    next_r.phase = 1'b0;
                    next_r.st    = dcc_pkg::DCC_HOLD;
                end
            end
            dcc_pkg::DCC_HOLD: begin
                if (bus_hold_grant) begin
                    if (xm == dcc_pkg::XM_CASCADE) begin
                        next_r.st = dcc_pkg::DCC_CASC;
                    end else begin
                        next_r.st = compressed ? dcc_pkg::DCC_RD
                                               : dcc_pkg::DCC_ADDR;
                    end
                end
            end
            dcc_pkg::DCC_CASC: begin
                if (!pend[r.ch] || !bus_hold_grant) begin
                    next_r.st   = dcc_pkg::DCC_IDLE;
                    next_r.last = r.ch;
                end
            end
            dcc_pkg::DCC_ADDR: next_r.st = dcc_pkg::DCC_RD;
            dcc_pkg::DCC_RD: begin
                if (!compressed) begin
                    next_r.st = dcc_pkg::DCC_WR;
                end else if (ready) begin
                    next_r.st = dcc_pkg::DCC_FIN;
                end
            end
            dcc_pkg::DCC_WR: begin
                if (ready) begin
                    next_r.st = dcc_pkg::DCC_FIN;
                end
            end
            dcc_pkg::DCC_FIN: begin
                if (copy && !r.phase) begin
                    // Source side of a copy moves only the address
                    if (!r.cmd[dcc_pkg::C_HOLD0]) begin
                        next_r.cur_addr[0] = r.cur_addr[0]
                            + (r.mode[0][dcc_pkg::MB_DEC]
                               ? ~dcc_pkg::CNT_ZERO : dcc_pkg::STEP_ONE);
                    end
                    next_r.phase = 1'b1;
                    next_r.st    = compressed ? dcc_pkg::DCC_RD
                                              : dcc_pkg::DCC_ADDR;
                end else begin
                    if (!(ech == 2'h0 && r.cmd[dcc_pkg::C_HOLD0])) begin
                        next_r.cur_addr[ech] = r.cur_addr[ech] + step;
                    end
                    next_r.cur_cnt[ech] = r.cur_cnt[ech]
                                          - dcc_pkg::STEP_ONE;
                    ending = (r.cur_cnt[ech] == dcc_pkg::CNT_ZERO)
                             || !end_of_process_in_n;
                    next_r.phase = 1'b0;
                    if (ending) begin
                        next_r.tc_flag[ech] = 1'b1;
                        next_r.sw_req[r.ch] = 1'b0;
                        if (r.mode[ech][dcc_pkg::MB_AUTO]) begin
                            next_r.cur_addr[ech] = r.base_addr[ech];
                            next_r.cur_cnt[ech]  = r.base_cnt[ech];
                        end else begin
                            next_r.mask[ech] = 1'b1;
                        end
                        next_r.st = dcc_pkg::DCC_IDLE;
                    end else if (xm == dcc_pkg::XM_BLOCK ||
                                 (xm == dcc_pkg::XM_DEMAND &&
                                  pend[r.ch])) begin
                        next_r.st = compressed ? dcc_pkg::DCC_RD
                                               : dcc_pkg::DCC_ADDR;
                    end else begin
                        // Single ends here; demand suspends here
                        next_r.st = dcc_pkg::DCC_IDLE;
                    end
                    if (next_r.st == dcc_pkg::DCC_IDLE) begin
                        next_r.last = r.ch;
                    end
                end
            end
            default: next_r.st = dcc_pkg::DCC_IDLE;
        endcase

        // Pins are registered from the next state
        xfer_on = (next_r.st == dcc_pkg::DCC_ADDR) ||
                  (next_r.st == dcc_pkg::DCC_RD) ||
                  (next_r.st == dcc_pkg::DCC_WR) ||
                  (next_r.st == dcc_pkg::DCC_FIN);
        rd_act = (next_r.st == dcc_pkg::DCC_RD) ||
                 (next_r.st == dcc_pkg::DCC_WR);
        wr_act = (next_r.st == dcc_pkg::DCC_WR) ||
                 ((next_r.st == dcc_pkg::DCC_RD) &&
                  (compressed || r.cmd[dcc_pkg::C_WS]));
        copy = r.cmd[dcc_pkg::C_MEMCPY] && (next_r.ch == 2'h0);
        dir  = r.mode[next_r.ch][dcc_pkg::MB_DIR +: 2];
        next_r.xo.bus_hold_request = (next_r.st != dcc_pkg::DCC_IDLE);
        next_r.xo.strb_oe_n = ~xfer_on;
        next_r.xo.addr = copy ? next_r.cur_addr[{1'b0, next_r.phase}]
                              : next_r.cur_addr[next_r.ch];
        // Verify matches neither direction, so no strobe moves data
        next_r.xo.memr_n = ~(rd_act && (copy ? !next_r.phase
                                             : dir == dcc_pkg::DIR_FR_MEM));
        next_r.xo.memw_n = ~(wr_act && (copy ? next_r.phase
                                             : dir == dcc_pkg::DIR_TO_MEM));
        next_r.xo.ior_n  = ~(rd_act && !copy && dir == dcc_pkg::DIR_TO_MEM);
        next_r.xo.iow_n  = ~(wr_act && !copy && dir == dcc_pkg::DIR_FR_MEM);
        grant = '0;
        if ((xfer_on && !copy) || next_r.st == dcc_pkg::DCC_CASC) begin
            grant[next_r.ch] = 1'b1;
        end
        next_r.xo.service_grant = r.cmd[dcc_pkg::C_ACK_HI] ? grant
                                                           : ~grant;
        next_r.xo.eop_oe_n = ~(ending && r.cur_cnt[ech] == dcc_pkg::CNT_ZERO);
        next_r.xo.end_of_process_n = next_r.xo.eop_oe_n;
        // Copy write phase drives the held byte onto the data bus
        if (xfer_on && copy && next_r.phase) begin
            next_r.ho.d      = next_r.temp;
            next_r.ho.d_oe_n = 1'b0;
        end else begin
            next_r.ho.d_oe_n = ~(next_r.rd_seen && idle);
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            r         <= '0;
            r.st      <= dcc_pkg::DCC_IDLE;
            r.cmd     <= dcc_pkg::CMD_RST;
            r.mask    <= dcc_pkg::MASK_RST;
            r.ho.d_oe_n <= 1'b1;
            r.xo.service_grant <= '1;
            r.xo.memr_n <= 1'b1;
            r.xo.memw_n <= 1'b1;
            r.xo.ior_n  <= 1'b1;
            r.xo.iow_n  <= 1'b1;
            r.xo.strb_oe_n <= 1'b1;
            r.xo.end_of_process_n <= 1'b1;
            r.xo.eop_oe_n <= 1'b1;
        end else begin
            r <= next_r;
        end
    end
endmodule

`default_nettype wire

// ===== dcc_pkg.sv
// Constants, field positions and state types of the four-channel DMA block
package dcc_pkg;
    localparam int NCH = 4;

    // Port indices on the 4-bit host address
    localparam logic [3:0] P_STAT_CMD  = 4'h8;
    localparam logic [3:0] P_REQ       = 4'h9;
    localparam logic [3:0] P_SMASK     = 4'hA;
    localparam logic [3:0] P_MODE      = 4'hB;
    localparam logic [3:0] P_CLR_PTR   = 4'hC;
    localparam logic [3:0] P_TEMP_MCLR = 4'hD;
    localparam logic [3:0] P_CLR_MASK  = 4'hE;
    localparam logic [3:0] P_AMASK     = 4'hF;
    localparam int A_WIDE  = 3;   // Clear: address/count ports
    localparam int A_COUNT = 0;   // Set: count, clear: address
    localparam int A_CH_LO = 1;   // Channel number of a 16-bit port

    // Command bits
    localparam int C_MEMCPY  = 0;
    localparam int C_HOLD0   = 1;
    localparam int C_DISABLE = 2;
    localparam int C_TIMING  = 3;
    localparam int C_PRIORITY_SCHEME_SELECT    = 4;
    localparam int C_WS      = 5;
    localparam int C_REQ_LOW = 6;
    localparam int C_ACK_HI  = 7;

    // Mode, request and mask byte fields
    localparam int SEL_LO   = 0;
    localparam int SET_BIT  = 2;
    localparam int MB_DIR   = 2;
    localparam int MB_AUTO  = 4;
    localparam int MB_DEC   = 5;
    localparam int MB_XM    = 6;

    localparam logic [1:0] XM_DEMAND  = 2'h0;
    localparam logic [1:0] XM_SINGLE  = 2'h1;
    localparam logic [1:0] XM_BLOCK   = 2'h2;
    localparam logic [1:0] XM_CASCADE = 2'h3;
    localparam logic [1:0] DIR_VERIFY = 2'h0;
    localparam logic [1:0] DIR_TO_MEM = 2'h1;
    localparam logic [1:0] DIR_FR_MEM = 2'h2;

    localparam logic [7:0]  CMD_RST   = 8'h00;
    localparam logic [3:0]  MASK_RST  = 4'hF;
    localparam logic [15:0] CNT_ZERO  = 16'h0000;
    localparam logic [15:0] STEP_ONE  = 16'h0001;
    localparam logic [7:0]  READ_NONE = 8'h00;

    typedef enum logic [6:0] {
        DCC_IDLE = 7'h01,
        DCC_HOLD = 7'h02,
        DCC_CASC = 7'h04,
        DCC_ADDR = 7'h08,
        DCC_RD   = 7'h10,
        DCC_WR   = 7'h20,
        DCC_FIN  = 7'h40
    } dcc_state_e_t;

    typedef struct packed {
        logic       cs_n;
        logic       rd_n;
        logic       wr_n;
        logic [3:0] a;
        logic [7:0] d;
    } dcc_host_in_t;

    typedef struct packed {
        logic [7:0] d;
        logic       d_oe_n;
    } dcc_host_out_t;

    typedef struct packed {
        logic        bus_hold_request;
        logic [3:0]  service_grant;
        logic [15:0] addr;
        logic        memr_n;
        logic        memw_n;
        logic        ior_n;
        logic        iow_n;
        logic        strb_oe_n;
        logic        end_of_process_n;
        logic        eop_oe_n;
    } dcc_xfer_out_t;

    typedef struct packed {
        dcc_state_e_t     st;
        logic [7:0]       cmd;
        logic [3:0][7:0]  mode;
        logic [3:0][15:0] cur_addr;
        logic [3:0][15:0] cur_cnt;
        logic [3:0][15:0] base_addr;
        logic [3:0][15:0] base_cnt;
        logic [3:0]       mask;
        logic [3:0]       sw_req;
        logic [3:0]       tc_flag;
        logic [7:0]       temp;
        logic             ptr;
        logic [1:0]       ch;
        logic [1:0]       last;
        logic             phase;
        logic             wr_seen;
        logic             rd_seen;
        dcc_host_out_t    ho;
        dcc_xfer_out_t    xo;
    } dcc_regs_t;
endpackage

// ===== dcc_host_model.sv
// Host bus arbiter model: answers hold requests promptly or slowly
`timescale 1ns/1ps
`default_nettype none

module dcc_host_model (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // Arbitration and pacing
    input  wire logic bus_hold_request,
    input  wire logic slow,
    output logic      bus_hold_grant,
    output logic      ready
);
    logic [1:0] wait_cnt;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bus_hold_grant <= 1'h0;
            wait_cnt       <= 2'h0;
            ready          <= 1'h1;
        end else if (!bus_hold_request) begin
            // Bus taken back at once, so each tenure needs a fresh grant
            bus_hold_grant <= 1'h0;
            wait_cnt       <= 2'h0;
            ready          <= 1'h1;
        end else begin
            wait_cnt       <= (wait_cnt == 2'h3) ? wait_cnt : wait_cnt + 2'h1;
            bus_hold_grant <= bus_hold_grant || !slow || wait_cnt == 2'h3;
            // A slow memory drops ready on every other clock
            ready          <= slow ? ~ready : 1'h1;
        end
    end
endmodule

`default_nettype wire

// ===== dcc_top_props.sv
// Port-level concurrent checks of the DMA controller
`timescale 1ns/1ps
`default_nettype none

module dcc_props (
    // Clock and reset
    input wire logic                   clk,
    input wire logic                   rst_b,
    // Host register port
    input wire dcc_pkg::dcc_host_in_t  host_i,
    input wire dcc_pkg::dcc_host_out_t host_o,
    // Peripheral and bus handshake
    input wire logic [3:0]             service_request_line,
    input wire logic                   bus_hold_grant,
    input wire logic                   ready,
    input wire logic                   end_of_process_in_n,
    input wire dcc_pkg::dcc_xfer_out_t xfer_o
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    // Shadow of the write-only command byte
    logic [7:0] cmd_q;
    logic       wr_q;
    logic       rd_q;
    logic [3:0] idle_g;

    assign idle_g = {4{~cmd_q[dcc_pkg::C_ACK_HI]}};

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_q <= dcc_pkg::CMD_RST;
            wr_q  <= 1'h0;
            rd_q  <= 1'h0;
        end else begin
            wr_q <= !host_i.cs_n && !host_i.wr_n;
            rd_q <= !host_i.cs_n && !host_i.rd_n;
            if (!host_i.cs_n && !host_i.wr_n && !wr_q
                    && !xfer_o.bus_hold_request) begin
                if (host_i.a == dcc_pkg::P_STAT_CMD) begin
                    cmd_q <= host_i.d;
                end else if (host_i.a == dcc_pkg::P_TEMP_MCLR) begin
                    cmd_q <= dcc_pkg::CMD_RST;
                end
            end
        end
    end

    sequence s_rd_take;
        !host_i.cs_n && !host_i.rd_n && !rd_q && !xfer_o.bus_hold_request;
    endsequence
    sequence s_rd_answer;
        !host_o.d_oe_n;
    endsequence
    sequence s_bus_start;
        $fell(xfer_o.strb_oe_n);
    endsequence

    chk_reset_values: assert property ($rose(rst_b) |->
        xfer_o.service_grant == 4'hF && !xfer_o.bus_hold_request)
        else $error("outputs not idle after reset");
    chk_grant_idle: assert property (!xfer_o.bus_hold_request
        && xfer_o.strb_oe_n && $stable(cmd_q) |-> xfer_o.service_grant == idle_g)
        else $error("idle grant polarity wrong");
    chk_disable_holds: assert property ($rose(xfer_o.bus_hold_request)
        |-> !$past(cmd_q[dcc_pkg::C_DISABLE]))
        else $error("hold request while disabled");
    chk_bus_granted: assert property (s_bus_start |->
        xfer_o.bus_hold_request && $past(bus_hold_grant))
        else $error("bus driven without grant");
    chk_grant_held: assert property (xfer_o.service_grant != idle_g
        && $stable(cmd_q) |-> $past(bus_hold_grant))
        else $error("acknowledge without hold grant");
    chk_eop_pulse: assert property ($fell(xfer_o.end_of_process_n)
        |=> xfer_o.end_of_process_n)
        else $error("end pulse longer than one cycle");
    chk_read_answer: assert property (s_rd_take |=> s_rd_answer)
        else $error("read data not driven");
    chk_io_exclusive: assert property (!xfer_o.ior_n |-> xfer_o.iow_n)
        else $error("both io strobes active");
    chk_mem_driven: assert property (!xfer_o.memw_n || !xfer_o.memr_n
        |-> !xfer_o.strb_oe_n && xfer_o.bus_hold_request)
        else $error("memory strobe while bus not owned");
endmodule

bind dcc_top dcc_props u_dcc_props (.clk(clk), .rst_b(rst_b),
    .host_i(host_i), .host_o(host_o),
    .service_request_line(service_request_line),
    .bus_hold_grant(bus_hold_grant), .ready(ready),
    .end_of_process_in_n(end_of_process_in_n), .xfer_o(xfer_o));

`default_nettype wire

// ===== dcc_top_tb.sv
// Self-checking bench for the DMA controller registers and transfers
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
    mismatches++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end

module dcc_top_tb;
    logic                   clk = 1'h0;
    logic                   rst_b = 1'h0;
    dcc_pkg::dcc_host_in_t  hi = '{1'h1, 1'h1, 1'h1, 4'h0, 8'h00};
    dcc_pkg::dcc_host_out_t ho;
    dcc_pkg::dcc_xfer_out_t xo;
    logic [3:0]             req = 4'h0;
    logic                   slow = 1'h0;
    logic                   eop_n = 1'h1;
    logic                   grant;
    logic                   rdy;
    logic [15:0]            addrs[$];
    logic [3:0]             gseen = 4'h0;
    logic                   mem_q = 1'h0;
    logic                   hrq_q = 1'h0;
    int                     checks = 0;
    int                     mismatches = 0;
    int                     tenures = 0;
    int                     eops = 0;
    int                     cycles = 0;

    always #2.5 clk = ~clk;

    dcc_top u_dcc_top (.clk(clk), .rst_b(rst_b), .host_i(hi), .host_o(ho),
        .service_request_line(req), .bus_hold_grant(grant), .ready(rdy),
        .end_of_process_in_n(eop_n), .xfer_o(xo));
    dcc_host_model u_dcc_host_model (.clk(clk), .rst_b(rst_b),
        .bus_hold_request(xo.bus_hold_request), .slow(slow),
        .bus_hold_grant(grant), .ready(rdy));

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Transfer monitor: one entry per memory strobe, tenures, end pulses
    always @(posedge clk) begin
        cycles++;
        if ((!xo.memr_n || !xo.memw_n) && !mem_q) begin
            addrs.push_back(xo.addr);
            gseen |= xo.service_grant;
        end
        mem_q = !xo.memr_n || !xo.memw_n;
        if (xo.bus_hold_request && !hrq_q) tenures++;
        hrq_q = xo.bus_hold_request;
        if (!xo.end_of_process_n) eops++;
        if (cycles == 20000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        tick(1);
        hi.cs_n = 1'h0;
        hi.wr_n = 1'h0;
        hi.a = a;
        hi.d = d;
        tick(1);
        hi.cs_n = 1'h1;
        hi.wr_n = 1'h1;
    endtask

    task automatic rdc(input logic [3:0] a, input logic [7:0] e,
                       input string nm);
        tick(1);
        hi.cs_n = 1'h0;
        hi.rd_n = 1'h0;
        hi.a = a;
        tick(2);
        `CHK(nm, e, ho.d)
        hi.cs_n = 1'h1;
        hi.rd_n = 1'h1;
    endtask

    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        wr(a, v[7:0]);
        wr(a, v[15:8]);
    endtask

    task automatic rdc16(input logic [3:0] a, input logic [15:0] v,
                         input string nm);
        rdc(a, v[7:0], nm);
        rdc(a, v[15:8], nm);
    endtask

    // Returns once the hold request has stayed low for 16 cycles
    task automatic settle();
        int q;
        q = 0;
        while (q < 16) begin
            @(posedge clk);
            q = xo.bus_hold_request ? 0 : q + 1;
        end
        #1;
    endtask

    task automatic clr();
        addrs.delete();
        tenures = 0;
        eops = 0;
        gseen = 4'h0;
    endtask

    initial begin
        tick(4);
        rst_b = 1'h1;
        rdc(dcc_pkg::P_STAT_CMD, 8'h00, "status");
        rdc(dcc_pkg::P_TEMP_MCLR, 8'h00, "temp");
        `CHK("grant idle", 4'hF, xo.service_grant)
        req = 4'h2;
        tick(20);
        `CHK("tenures", 0, tenures)
        rdc(dcc_pkg::P_STAT_CMD, 8'h20, "status");
        wr(dcc_pkg::P_CLR_PTR, 8'h00);
        wr16(4'h2, 16'hA55A);
        wr16(4'h3, 16'h0102);
        rdc16(4'h2, 16'hA55A, "addr1");
        rdc16(4'h3, 16'h0102, "count1");
        wr(4'h2, 8'h77);
        wr(dcc_pkg::P_CLR_PTR, 8'h00);
        rdc16(4'h2, 16'hA577, "addr1 low");
        // Single mode, increment, two transfers on channel 0
        wr(dcc_pkg::P_MODE, 8'h44);
        wr16(4'h0, 16'h1234);
        wr16(4'h1, 16'h0001);
        wr(dcc_pkg::P_SMASK, 8'h00);
        clr();
        req = 4'h1;
        settle();
        req = 4'h0;
        `CHK("tenures", 2, tenures)
        `CHK("xfers", 2, addrs.size())
        `CHK("addr a", 16'h1234, addrs[0])
        `CHK("addr b", 16'h1235, addrs[1])
        `CHK("eop", 1, eops)
        rdc16(4'h1, 16'hFFFF, "count0");
        rdc16(4'h0, 16'h1236, "addr0");
        rdc(dcc_pkg::P_STAT_CMD, 8'h01, "status");
        rdc(dcc_pkg::P_STAT_CMD, 8'h00, "status");
        req = 4'h1;
        tick(20);
        req = 4'h0;
        `CHK("tenures", 2, tenures)
        // Block, decrement, auto-init, software request on masked ch 2
        slow = 1'h1;
        wr(dcc_pkg::P_MODE, 8'hBA);
        wr16(4'h4, 16'h0050);
        wr16(4'h5, 16'h0002);
        clr();
        wr(dcc_pkg::P_REQ, 8'h06);
        settle();
        slow = 1'h0;
        `CHK("tenures", 1, tenures)
        `CHK("xfers", 3, addrs.size())
        `CHK("addr last", 16'h004E, addrs[2])
        clr();
        eop_n = 1'h0;
        wr(dcc_pkg::P_REQ, 8'h06);
        settle();
        eop_n = 1'h1;
        `CHK("xfers", 1, addrs.size())
        `CHK("eop", 0, eops)
        rdc16(4'h4, 16'h0050, "addr2");
        rdc16(4'h5, 16'h0002, "count2");
        rdc(dcc_pkg::P_STAT_CMD, 8'h04, "status");
        // Demand on ch 3, inverted polarities, first disabled
        req = 4'hF;
        wr(dcc_pkg::P_STAT_CMD, 8'hC4);
        tick(2);
        `CHK("grant idle", 4'h0, xo.service_grant)
        wr(dcc_pkg::P_MODE, 8'h07);
        wr16(4'h6, 16'h0100);
        wr16(4'h7, 16'h0003);
        wr(dcc_pkg::P_AMASK, 8'h07);
        clr();
        req = 4'h7;
        tick(20);
        `CHK("tenures", 0, tenures)
        wr(dcc_pkg::P_STAT_CMD, 8'hC0);
        for (int i = 0; i < 400 && addrs.size() < 2; i++) tick(1);
        req = 4'hF;
        settle();
        rdc(dcc_pkg::P_STAT_CMD, 8'h00, "status");
        req = 4'h7;
        settle();
        req = 4'hF;
        `CHK("xfers", 4, addrs.size())
        `CHK("addr last", 16'h0103, addrs[3])
        `CHK("grant seen", 4'h8, gseen)
        rdc(dcc_pkg::P_STAT_CMD, 8'h08, "status");
        // Master clear restores polarity and masks every channel
        wr(dcc_pkg::P_TEMP_MCLR, 8'h00);
        clr();
        tick(20);
        `CHK("grant idle", 4'hF, xo.service_grant)
        `CHK("tenures", 0, tenures)
        rdc(dcc_pkg::P_STAT_CMD, 8'hF0, "status");
        end_sim();
    end
endmodule

`default_nettype wire
